//--- src/rct_cfg.svh
// Offsets, field positions, reset values and timing counts of the reference/trigger front end
`ifndef RCT_CFG_SVH
`define RCT_CFG_SVH

`define RCT_CLK_MHZ          100
`define RCT_TB20_MHZ         20
`define RCT_TB100K_KHZ       100
`define RCT_REFOUT_MHZ       10
`define RCT_DIV20            (`RCT_CLK_MHZ / `RCT_TB20_MHZ)
`define RCT_DIV100K          ((`RCT_CLK_MHZ * 1000) / `RCT_TB100K_KHZ)
`define RCT_REFOUT_HALF      (`RCT_CLK_MHZ / `RCT_REFOUT_MHZ / 2)

`define RCT_FILT_SHORT_NS    90
`define RCT_FILT_MID_NS      5120
`define RCT_FILT_LONG_NS     2560000
`define RCT_CYC_MIN(ns)      (((ns) * `RCT_CLK_MHZ + 999) / 1000)
`define RCT_FILT_SHORT_CYC   `RCT_CYC_MIN(`RCT_FILT_SHORT_NS)
`define RCT_FILT_MID_CYC     `RCT_CYC_MIN(`RCT_FILT_MID_NS)
`define RCT_FILT_LONG_CYC    `RCT_CYC_MIN(`RCT_FILT_LONG_NS)

`define RCT_ADDR_W           5
`define RCT_OFS_CTRL         5'h00
`define RCT_OFS_CMD          5'h04
`define RCT_OFS_CUSTOM       5'h08
`define RCT_OFS_PRE          5'h0c
`define RCT_OFS_POST         5'h10
`define RCT_OFS_STATUS       5'h14

`define RCT_CTRL_REFSRC      2:0
`define RCT_CTRL_REFLINE     5:3
`define RCT_CTRL_TRGSRC      9:6
`define RCT_CTRL_SENSE       11:10
`define RCT_CTRL_MODE        13:12
`define RCT_CTRL_FILTEN      14
`define RCT_CTRL_FILTSEL     16:15
`define RCT_CTRL_SKEWEN      17
`define RCT_CTRL_ROLE        18
`define RCT_CTRL_REFOUTEN    19
`define RCT_CTRL_REFOUTLINE  22:20
`define RCT_CTRL_SHARELINE   25:23
`define RCT_CTRL_W           26
`define RCT_CTRL_RESET       26'h0000000

`define RCT_CMD_ARM          0
`define RCT_CMD_STOP         1

`define RCT_CNT_W            20
`define RCT_CUSTOM_RESET     20'h00009
`define RCT_PRE_RESET        20'h00000
`define RCT_POST_RESET       20'h00000

`define RCT_ST_LOCKED        0
`define RCT_ST_RUNNING       1
`define RCT_ST_PAUSED        2
`define RCT_ST_TRIGGERED     3
`define RCT_ST_DONE          4
`define RCT_ST_STATE         7:5

`endif

//--- src/rct_pkg.sv
// Types shared by the reference/trigger front end
package rct_pkg;

   typedef enum logic [2:0] {
      RCT_REF_TRIG   = 3'h0,
      RCT_REF_CLK100 = 3'h1,
      RCT_REF_STAR   = 3'h2,
      RCT_REF_DSTARA = 3'h3,
      RCT_REF_DSTARB = 3'h4
   } rct_ref_src_t;

   typedef enum logic [1:0] {
      RCT_SENSE_RISE = 2'h0,
      RCT_SENSE_FALL = 2'h1,
      RCT_SENSE_HIGH = 2'h2,
      RCT_SENSE_LOW  = 2'h3
   } rct_sense_t;

   typedef enum logic [1:0] {
      RCT_MODE_START = 2'h0,
      RCT_MODE_REF   = 2'h1,
      RCT_MODE_PAUSE = 2'h2
   } rct_mode_t;

   typedef enum logic [2:0] {
      RCT_ST_IDLE  = 3'h0,
      RCT_ST_PRE   = 3'h1,
      RCT_ST_WAIT  = 3'h2,
      RCT_ST_POST  = 3'h3,
      RCT_ST_RUN   = 3'h4
   } rct_state_t;

endpackage : rct_pkg

//--- src/rct_sync2.sv
// Two-flop synchroniser, one chain per bit
module rct_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta;
         always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               meta <= 1'b0;
               q[i] <= 1'b0;
            end else begin
               meta <= d[i];
               q[i] <= meta;
            end
         end
      end
   endgenerate
endmodule : rct_sync2

//--- src/rct_trig_filter.sv
// Debounce filter: output follows input only after it has held for limit cycles
`include "rct_cfg.svh"
module rct_trig_filter (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic                   d,
   input  wire logic                   en,
   input  wire logic [`RCT_CNT_W-1:0]  limit,
   output logic                        q
);
   logic [`RCT_CNT_W-1:0] cnt;
   wire                   differs  = d != q;
   wire                   held     = (cnt + `RCT_CNT_W'h1) >= limit;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         q   <= 1'b0;
      end else if (!en) begin
         cnt <= '0;
         q   <= d;
      end else if (!differs) begin
         cnt <= '0;
      end else if (held) begin
         cnt <= '0;
         q   <= d;
      end else begin
         cnt <= cnt + `RCT_CNT_W'h1;
      end
   end
endmodule : rct_trig_filter

//--- src/rct_frontend.sv
// Reference clock selection, timebases, 10 MHz output and trigger conditioning
// Overview of operation
// - Lock the PLL to the chosen reference; derive 100 MHz, 20 MHz, 100 kHz timebases.
// - Reference source is a trigger line, backplane 100 MHz, star, or differential star A/B.
// - The 10 MHz reference can be driven onto any chosen trigger bus line.
// - The 10 MHz reference comes from dividing the on-board oscillator.
// - With skew correction, start and reference mode triggers act on a later 10 MHz sync edge.
// - Skew correction role is configurable as master or slave.
// - Trigger comes from star A/B, any of eight bus lines, or the star line.
// - Trigger sensitivity is rising edge, falling edge or level.
// - Start mode begins the operation when the trigger is met.
// - Reference mode keeps programmed pre-trigger and post-trigger sample counts.
// - Pause mode holds operation while the level condition holds; level only.
// - Filter accepts trigger after 90 ns, 5.12 us, 2.56 ms or custom persistence.
`include "rct_cfg.svh"
module rct_frontend
   import rct_pkg::*;
#(
   parameter int FILT_LONG_CYC = `RCT_FILT_LONG_CYC
) (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic [`RCT_ADDR_W-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic [7:0]            trig_in,
   output logic      [7:0]            trig_out,
   output logic      [7:0]            trig_oe,
   input  wire logic                  star_in,
   input  wire logic                  dstar_a_in,
   input  wire logic                  dstar_b_in,
   input  wire logic                  sync100_in,
   input  wire logic                  pll_locked,
   output logic      [2:0]            pll_ref_sel,
   output logic      [2:0]            pll_ref_line,
   input  wire logic                  sample_tick,
   output logic                       tb100m_en,
   output logic                       tb20m_en,
   output logic                       tb100k_en,
   output logic                       ten_mhz_reference_output,
   output logic                       trig_fire,
   output logic                       run_active,
   output logic                       pause_active,
   output logic                       gen_done
);

   // Bus slave: every access is answered one cycle after it is presented
   logic                   ack;
   logic [`RCT_CTRL_W-1:0] ctrl;
   logic [`RCT_CNT_W-1:0]  custom_cyc;
   logic [`RCT_CNT_W-1:0]  pre_cnt_cfg;
   logic [`RCT_CNT_W-1:0]  post_cnt_cfg;
   logic                   triggered;
   logic                   done_flag;
   logic [31:0]            status_word;
   logic [31:0]            rd_mux;

   wire req       = avs_read | avs_write;
   wire wr_do     = avs_write & ack;
   wire sel_ctrl  = avs_address == `RCT_OFS_CTRL;
   wire sel_cmd   = avs_address == `RCT_OFS_CMD;
   wire sel_cust  = avs_address == `RCT_OFS_CUSTOM;
   wire sel_pre   = avs_address == `RCT_OFS_PRE;
   wire sel_post  = avs_address == `RCT_OFS_POST;
   wire sel_stat  = avs_address == `RCT_OFS_STATUS;
   wire arm_cmd   = wr_do & sel_cmd & avs_writedata[`RCT_CMD_ARM];
   wire stop_cmd  = wr_do & sel_cmd & avs_writedata[`RCT_CMD_STOP];

   assign avs_waitrequest = req & ~ack;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl         <= `RCT_CTRL_RESET;
         custom_cyc   <= `RCT_CUSTOM_RESET;
         pre_cnt_cfg  <= `RCT_PRE_RESET;
         post_cnt_cfg <= `RCT_POST_RESET;
      end else if (wr_do) begin
         if (sel_ctrl) ctrl <= avs_writedata[`RCT_CTRL_W-1:0];
         if (sel_cust) custom_cyc <= avs_writedata[`RCT_CNT_W-1:0];
         if (sel_pre) pre_cnt_cfg <= avs_writedata[`RCT_CNT_W-1:0];
         if (sel_post) post_cnt_cfg <= avs_writedata[`RCT_CNT_W-1:0];
      end
   end

   assign rd_mux = sel_ctrl ? {{(32-`RCT_CTRL_W){1'b0}}, ctrl} :
                   sel_cust ? {{(32-`RCT_CNT_W){1'b0}}, custom_cyc} :
                   sel_pre  ? {{(32-`RCT_CNT_W){1'b0}}, pre_cnt_cfg} :
                   sel_post ? {{(32-`RCT_CNT_W){1'b0}}, post_cnt_cfg} :
                   sel_stat ? status_word : 32'h00000000;

   // Read data is loaded in the waiting cycle so it stands when waitrequest drops
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h00000000;
      end else if (avs_read & ~ack) begin
         avs_readdata <= rd_mux;
      end
   end

   // Control fields
   wire [2:0] ref_src    = ctrl[`RCT_CTRL_REFSRC];
   wire [3:0] trg_src    = ctrl[`RCT_CTRL_TRGSRC];
   wire [1:0] sense      = ctrl[`RCT_CTRL_SENSE];
   wire [1:0] mode       = ctrl[`RCT_CTRL_MODE];
   wire [1:0] filt_sel   = ctrl[`RCT_CTRL_FILTSEL];
   wire       skew_en    = ctrl[`RCT_CTRL_SKEWEN];
   wire       skew_correction_role = ctrl[`RCT_CTRL_ROLE];
   wire       refout_en  = ctrl[`RCT_CTRL_REFOUTEN];
   wire [2:0] refout_ln  = ctrl[`RCT_CTRL_REFOUTLINE];
   wire [2:0] share_ln   = ctrl[`RCT_CTRL_SHARELINE];

   // Analog clock mux in front of the PLL is steered by code, never by gated clocks
   assign pll_ref_sel  = ref_src;
   assign pll_ref_line = ctrl[`RCT_CTRL_REFLINE];

   // Backplane pins into the clock domain
   logic [12:0] pins_s;
   rct_sync2 #(.W(13)) u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     ({pll_locked, sync100_in, dstar_b_in, dstar_a_in, star_in, trig_in}),
      .q     (pins_s)
   );

   wire [7:0] trig_s   = pins_s[7:0];
   wire       star_s   = pins_s[8];
   wire       dstara_s = pins_s[9];
   wire       dstarb_s = pins_s[10];
   wire       sync_s   = pins_s[11];
   wire       locked_s = pins_s[12];

   // Timebases run only with the PLL locked; the system clock is the PLL output
   logic [2:0] div20;
   logic [9:0] div100k;
   logic [2:0] div10;
   wire        div20_wrap  = div20 == 3'(`RCT_DIV20 - 1);
   wire        div100k_wrap = div100k == 10'(`RCT_DIV100K - 1);
   wire        div10_wrap  = div10 == 3'(`RCT_REFOUT_HALF - 1);

   assign tb100m_en = locked_s;
   assign tb20m_en  = locked_s & div20_wrap;
   assign tb100k_en = locked_s & div100k_wrap;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div20   <= 3'h0;
         div100k <= 10'h000;
      end else if (!locked_s) begin
         div20   <= 3'h0;
         div100k <= 10'h000;
      end else begin
         div20   <= div20_wrap ? 3'h0 : div20 + 3'h1;
         div100k <= div100k_wrap ? 10'h000 : div100k + 10'h001;
      end
   end

   // Oscillator-derived 10 MHz runs free so peers keep a reference while we relock
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         div10                    <= 3'h0;
         ten_mhz_reference_output <= 1'b0;
      end else if (div10_wrap) begin
         div10                    <= 3'h0;
         ten_mhz_reference_output <= ~ten_mhz_reference_output;
      end else begin
         div10 <= div10 + 3'h1;
      end
   end

   // Trigger source: 0..7 bus lines, 8 star, 9 dstar A, 10 dstar B
   wire trg_raw = (trg_src < 4'h8) ? trig_s[trg_src[2:0]] :
                  (trg_src == 4'h8) ? star_s :
                  (trg_src == 4'h9) ? dstara_s :
                  (trg_src == 4'ha) ? dstarb_s : 1'b0;

   wire [`RCT_CNT_W-1:0] filt_limit =
      (filt_sel == 2'h0) ? `RCT_CNT_W'(`RCT_FILT_SHORT_CYC) :
      (filt_sel == 2'h1) ? `RCT_CNT_W'(`RCT_FILT_MID_CYC) :
      (filt_sel == 2'h2) ? `RCT_CNT_W'(FILT_LONG_CYC) : custom_cyc;

   logic trg_filt;
   rct_trig_filter u_filt (
      .clock (clock),
      .rst_n (rst_n),
      .d     (trg_raw),
      .en    (ctrl[`RCT_CTRL_FILTEN]),
      .limit (filt_limit),
      .q     (trg_filt)
   );

   logic trg_prev;
   logic sync_prev;
   logic pending;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         trg_prev  <= 1'b0;
         sync_prev <= 1'b0;
      end else begin
         trg_prev  <= trg_filt;
         sync_prev <= sync_s;
      end
   end

   // Pause mode ignores edge settings and uses the polarity bit as a level
   wire pause_mode = mode == RCT_MODE_PAUSE;
   wire level_cond = sense[0] ? ~trg_filt : trg_filt;
   wire trg_event  = (sense == RCT_SENSE_RISE) ? (trg_filt & ~trg_prev) :
                     (sense == RCT_SENSE_FALL) ? (~trg_filt & trg_prev) : level_cond;
   wire sync_edge  = sync_s & ~sync_prev;
   wire trg_accept = skew_en ? ((pending | trg_event) & sync_edge) : trg_event;

   // Trigger waiting for a sync edge; a new event in the clearing cycle is taken by that edge, not kept
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 1'b0;
      end else if (!skew_en) begin
         pending <= 1'b0;
      end else if (sync_edge) begin
         pending <= 1'b0;
      end else if (trg_event) begin
         pending <= 1'b1;
      end
   end

   // Sequencer
   rct_state_t             state;
   rct_state_t             next_state;
   logic [`RCT_CNT_W-1:0]  samp_cnt;
   wire                    pre_full  = samp_cnt >= pre_cnt_cfg;
   wire                    post_full = samp_cnt >= post_cnt_cfg;

   always_comb begin
      next_state = state;
      unique case (state)
         RCT_ST_IDLE: begin
            if (arm_cmd) begin
               next_state = (mode == RCT_MODE_REF) ? RCT_ST_PRE :
                            pause_mode ? RCT_ST_RUN : RCT_ST_WAIT;
            end
         end
         RCT_ST_PRE: begin
            if (pre_full) next_state = RCT_ST_WAIT;
         end
         RCT_ST_WAIT: begin
            if (trg_accept) begin
               next_state = (mode == RCT_MODE_REF) ? RCT_ST_POST : RCT_ST_RUN;
            end
         end
         RCT_ST_POST: begin
            if (post_full) next_state = RCT_ST_IDLE;
         end
         RCT_ST_RUN: begin
            next_state = RCT_ST_RUN;
         end
         default: begin
            next_state = RCT_ST_IDLE;
         end
      endcase
      if (stop_cmd) next_state = RCT_ST_IDLE;
   end

   wire in_wait     = state == RCT_ST_WAIT;
   wire fire_now    = in_wait & trg_accept;
   wire post_end    = (state == RCT_ST_POST) & post_full & ~stop_cmd;
   wire counting    = (state == RCT_ST_PRE) | (state == RCT_ST_POST);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state    <= RCT_ST_IDLE;
         samp_cnt <= '0;
      end else begin
         state <= next_state;
         if (next_state != state) begin
            samp_cnt <= '0;
         end else if (counting & sample_tick & locked_s) begin
            samp_cnt <= samp_cnt + `RCT_CNT_W'h1;
         end
      end
   end

   // Sticky flags: a set in the arm cycle wins over the arm clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         triggered <= 1'b0;
         done_flag <= 1'b0;
         trig_fire <= 1'b0;
      end else begin
         trig_fire <= fire_now;
         if (fire_now) triggered <= 1'b1;
         else if (arm_cmd) triggered <= 1'b0;
         if (post_end) done_flag <= 1'b1;
         else if (arm_cmd) done_flag <= 1'b0;
      end
   end

   assign gen_done     = done_flag;
   assign run_active   = (state == RCT_ST_RUN) | counting;
   assign pause_active = (state == RCT_ST_RUN) & pause_mode & level_cond;

   assign status_word = {24'h000000, state, done_flag, triggered, pause_active, run_active,
                         locked_s};

   // Bus line drivers: reference output wins over the shared trigger on the same line
   genvar ln;
   generate
      for (ln = 0; ln < 8; ln++) begin : g_line
         wire ref_here   = refout_en & (refout_ln == 3'(ln));
         wire share_here = skew_en & skew_correction_role & (share_ln == 3'(ln));
         assign trig_oe[ln]  = ref_here | share_here;
         assign trig_out[ln] = ref_here ? ten_mhz_reference_output : trig_fire;
      end
   endgenerate

endmodule : rct_frontend

//--- bench/rct_frontend_assertions.sv
// Port-level checker of the front end
module rct_frontend_assertions (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       avs_read,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   input wire logic       pll_locked,
   input wire logic [2:0] pll_ref_sel,
   input wire logic       tb100m_en,
   input wire logic       tb20m_en,
   input wire logic       tb100k_en,
   input wire logic       ten_mhz_reference_output,
   input wire logic       trig_fire,
   input wire logic       run_active,
   input wire logic       pause_active,
   input wire logic       gen_done
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Cycles since last 100 kHz pulse
   logic [9:0] gap;
   logic       seen;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gap  <= 10'h000;
         seen <= 1'b0;
      end else if (tb100k_en) begin
         gap  <= 10'h000;
         seen <= 1'b1;
      end else begin
         gap  <= gap + 10'h001;
      end
   end

   acc_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1
      !avs_waitrequest) else $error("wait state wrong");
   refout_period_a: assert property ($changed(ten_mhz_reference_output) |=>
      $stable(ten_mhz_reference_output)[*4] ##1 $changed(ten_mhz_reference_output))
      else $error("ref out period wrong");
   tb20_period_a: assert property (tb20m_en |=> !tb20m_en[*4] ##1 (tb20m_en || !tb100m_en))
      else $error("20 MHz spacing wrong");
   tb20_lock_a: assert property (tb20m_en |-> tb100m_en)
      else $error("20 MHz without lock");
   tb100k_gap_a: assert property (tb100k_en && seen |-> gap == 10'd999)
      else $error("100 kHz spacing wrong");
   lock_follow_a: assert property ($rose(pll_locked) |-> ##[2:3] tb100m_en)
      else $error("no timebase after lock");
   ref_sel_write_a: assert property ($changed(pll_ref_sel) |->
      $past(avs_write && !avs_waitrequest)) else $error("reference source moved alone");
   fire_pulse_a: assert property (trig_fire |=> !trig_fire)
      else $error("fire longer than a cycle");
   pause_run_a: assert property (pause_active |-> run_active)
      else $error("pause while idle");
   done_rise_a: assert property ($rose(gen_done) |-> $past(run_active))
      else $error("done without operation");
   done_fall_a: assert property ($fell(gen_done) |-> $past(avs_write))
      else $error("done cleared alone");

   cover property (trig_fire);
   cover property ($rose(pause_active));
   cover property ($rose(gen_done));
endmodule : rct_frontend_assertions

bind rct_frontend rct_frontend_assertions rct_frontend_assertions_i (.clock, .rst_n,
   .avs_read, .avs_write, .avs_waitrequest, .pll_locked, .pll_ref_sel, .tb100m_en,
   .tb20m_en, .tb100k_en, .ten_mhz_reference_output, .trig_fire, .run_active,
   .pause_active, .gen_done);

//--- bench/rct_backplane_model.sv
// Backplane side: sync clock, lock and star clocks
module rct_backplane_model (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic star_clk_en,
   output logic      sync100_in,
   output logic      pll_locked,
   output logic      star_in,
   output logic      dstar_a_in
);
   logic [3:0] cnt;
   logic [7:0] up;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 4'h0;
         up  <= 8'h00;
      end else begin
         cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
         up  <= (up == 8'h14) ? up : up + 8'h01;
      end
   end
   // One high cycle in ten
   assign sync100_in = (cnt == 4'h0);
   // Reference never removed, so lock holds
   assign pll_locked = (up == 8'h14);
   // Star controller clocks star line when asked
   assign star_in    = star_clk_en & (cnt > 4'h4);
   assign dstar_a_in = (cnt < 4'h5);
endmodule : rct_backplane_model

//--- bench/tb_rct_frontend.sv
// Self-checking bench for the reference/trigger front end
`include "rct_cfg.svh"
module tb_rct_frontend
   import rct_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rdat;
   logic        avs_waitrequest;
   logic [7:0]  trig_in = 8'h00;
   logic [7:0]  trig_out, trig_oe;
   logic        dstar_b_in = 1'b0, sample_tick = 1'b0, star_clk_en = 1'b0;
   logic        star_in, dstar_a_in, sync100_in, pll_locked;
   logic [2:0]  pll_ref_sel, pll_ref_line;
   logic        tb100m_en, tb20m_en, tb100k_en, ten_mhz_reference_output;
   logic        trig_fire, run_active, pause_active, gen_done;
   int          n_mismatch = 0;
   int          n_checks = 0;

   always #5 clock = ~clock;

   rct_frontend #(.FILT_LONG_CYC(20)) rct_frontend_i (.clock, .rst_n, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .trig_in,
      .trig_out, .trig_oe, .star_in, .dstar_a_in, .dstar_b_in, .sync100_in, .pll_locked,
      .pll_ref_sel, .pll_ref_line, .sample_tick, .tb100m_en, .tb20m_en, .tb100k_en,
      .ten_mhz_reference_output, .trig_fire, .run_active, .pause_active, .gen_done);
   rct_backplane_model rct_backplane_model_i (.clock, .rst_n, .star_clk_en, .sync100_in,
      .pll_locked, .star_in, .dstar_a_in);

   task automatic tally_and_finish();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         $display("BAD %0t %s", $time, what);
         n_mismatch++;
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc

   // Request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n = 0;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         n++;
         @(posedge clock);
      end
      chk(32'(n < 20), 32'h1, "no answer");
      rdat = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clock);
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rchk(input logic [4:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      chk(rdat, exp, what);
   endtask : rchk

   task automatic pin(input int src, input logic v);
      if (src < 8)
         trig_in[src] <= v;
      else if (src == 8)
         star_clk_en <= v;
      else if (src == 10)
         dstar_b_in <= v;
   endtask : pin

   task automatic tick();
      sample_tick <= 1'b1;
      @(posedge clock);
      sample_tick <= 1'b0;
      @(posedge clock);
   endtask : tick

   task automatic wait_fire(output int n);
      n = 0;
      while (trig_fire !== 1'b1 && n < 60) begin
         @(posedge clock);
         n++;
      end
   endtask : wait_fire

   task automatic t_regs();
      rchk(`RCT_OFS_CTRL, 32'h0, "ctrl reset");
      rchk(`RCT_OFS_CUSTOM, 32'h9, "custom reset");
      rchk(`RCT_OFS_PRE, 32'h0, "pre reset");
      wr(`RCT_OFS_POST, 32'hffffffff);
      rchk(`RCT_OFS_POST, 32'h000fffff, "post width");
      wr(5'h18, 32'hffffffff);
      rchk(5'h18, 32'h0, "unmapped read");
      rchk(`RCT_OFS_CMD, 32'h0, "cmd read");
      rchk(`RCT_OFS_STATUS, 32'h1, "idle status");
   endtask : t_regs

   task automatic t_refout();
      int n;
      logic v;
      for (int s = 0; s < 5; s++) begin
         wr(`RCT_OFS_CTRL, 32'(s) | 32'h30);
         chk({29'h0, pll_ref_sel}, 32'(s), "ref source");
         chk({29'h0, pll_ref_line}, 32'h6, "ref line");
      end
      wr(`RCT_OFS_CTRL, 32'h00580000);
      chk({24'h0, trig_oe}, 32'h20, "ref out enable");
      for (int k = 0; k < 2; k++) begin
         v = trig_out[5];
         n = 0;
         while (trig_out[5] === v && n < 20) begin
            @(posedge clock);
            n++;
         end
      end
      chk(32'(n), 32'h5, "ref out half period");
   endtask : t_refout

   task automatic t_start(input int src, input logic [1:0] sense);
      int n;
      logic act;
      act = (sense == RCT_SENSE_RISE || sense == RCT_SENSE_HIGH);
      pin(src, !act);
      wr(`RCT_OFS_CTRL, (32'(src) << 6) | (32'(sense) << 10));
      if (src == 9)
         @(negedge dstar_a_in) @(posedge clock);
      wr(`RCT_OFS_CMD, 32'h1);
      rchk(`RCT_OFS_STATUS, {24'h0, RCT_ST_WAIT, 5'h01}, "armed");
      pin(src, act);
      wait_fire(n);
      chk(32'(n >= 3 && n < 40), 32'h1, "fire latency");
      rchk(`RCT_OFS_STATUS, {24'h0, RCT_ST_RUN, 5'h0b}, "running");
      wr(`RCT_OFS_CMD, 32'h2);
      pin(src, !act);
   endtask : t_start

   task automatic t_ref();
      int n;
      wr(`RCT_OFS_PRE, 32'h2);
      wr(`RCT_OFS_POST, 32'h3);
      wr(`RCT_OFS_CTRL, 32'h00001040);
      pin(1, 1'b0);
      wr(`RCT_OFS_CMD, 32'h1);
      tick();
      rchk(`RCT_OFS_STATUS, {24'h0, RCT_ST_PRE, 5'h03}, "pre count");
      tick();
      cyc(2);
      rchk(`RCT_OFS_STATUS, {24'h0, RCT_ST_WAIT, 5'h01}, "pre done");
      pin(1, 1'b1);
      wait_fire(n);
      tick();
      tick();
      chk({30'h0, gen_done, run_active}, 32'h1, "post running");
      tick();
      cyc(2);
      chk({30'h0, gen_done, run_active}, 32'h2, "post count end");
      wr(`RCT_OFS_CMD, 32'h1);
      chk({31'h0, gen_done}, 32'h0, "arm clears done");
      wr(`RCT_OFS_CMD, 32'h2);
      pin(1, 1'b0);
   endtask : t_ref

   task automatic t_pause();
      pin(4, 1'b0);
      // Edge sense on purpose: pause acts on level
      wr(`RCT_OFS_CTRL, 32'h00002100);
      wr(`RCT_OFS_CMD, 32'h1);
      cyc(4);
      chk({30'h0, run_active, pause_active}, 32'h2, "unpaused");
      pin(4, 1'b1);
      cyc(20);
      chk({30'h0, run_active, pause_active}, 32'h3, "paused");
      pin(4, 1'b0);
      cyc(6);
      chk({30'h0, run_active, pause_active}, 32'h2, "resumed");
      wr(`RCT_OFS_CMD, 32'h2);
   endtask : t_pause

   task automatic t_filt(input logic [1:0] sel, input int lim);
      int n;
      pin(3, 1'b0);
      wr(`RCT_OFS_CTRL, 32'h000040c0 | (32'(sel) << 15));
      wr(`RCT_OFS_CMD, 32'h1);
      pin(3, 1'b1);
      cyc(lim - 3);
      pin(3, 1'b0);
      wait_fire(n);
      chk(32'(n), 32'd60, "short pulse rejected");
      pin(3, 1'b1);
      wait_fire(n);
      chk(32'(n > lim && n < lim + 10), 32'h1, "filtered latency");
      wr(`RCT_OFS_CMD, 32'h2);
      pin(3, 1'b0);
   endtask : t_filt

   task automatic t_skew();
      int n;
      pin(1, 1'b0);
      wr(`RCT_OFS_CTRL, 32'h03060040);
      chk({24'h0, trig_oe}, 32'h40, "master drives line");
      wr(`RCT_OFS_CMD, 32'h1);
      while (sync100_in !== 1'b1)
         @(posedge clock);
      cyc(3);
      pin(1, 1'b1);
      wait_fire(n);
      chk(32'(n >= 8 && n < 20), 32'h1, "fire waits for sync");
      wr(`RCT_OFS_CMD, 32'h2);
      wr(`RCT_OFS_CTRL, 32'h03020040);
      chk({24'h0, trig_oe}, 32'h0, "slave releases line");
      pin(1, 1'b0);
   endtask : t_skew

   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      cyc(30);
      t_regs();
      t_refout();
      t_start(2, RCT_SENSE_RISE);
      t_start(10, RCT_SENSE_FALL);
      t_start(7, RCT_SENSE_HIGH);
      t_start(0, RCT_SENSE_LOW);
      t_start(8, RCT_SENSE_RISE);
      t_start(9, RCT_SENSE_RISE);
      t_ref();
      t_pause();
      wr(`RCT_OFS_CUSTOM, 32'd30);
      t_filt(2'h0, 9);
      t_filt(2'h2, 20);
      t_filt(2'h3, 30);
      t_skew();
      tally_and_finish();
   end

   // About forty times the expected run
   initial begin
      #300us;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : tb_rct_frontend
